// ### verilog/wake_wd_pkg.sv
`default_nettype none
package wake_wd_pkg;
   // register indices; byte address on the bus is four times the index
   localparam logic [15:0] IDX_RESTART = 16'h00F8;
   localparam logic [15:0] IDX_OVF_STATUS = 16'h2002;
   localparam logic [15:0] IDX_WAKE_CTRL = 16'h20A9;
   localparam logic [15:0] IDX_FLAGS = 16'h20B1;
   localparam logic [15:0] IDX_IRQ_STATUS = 16'h20C0;
   localparam logic [15:0] IDX_IRQ_MASK = 16'h20C1;
   // field positions
   localparam int RESTART_BIT = 7;
   localparam int OVF_BIT = 2;
   localparam int PRD_LSB = 0;
   localparam int RES_BIT = 3;
   localparam int ARM_BIT = 7;
   localparam int WARN_BIT = 0;
   localparam int IRQ_WARN = 0;
   localparam int IRQ_OVF = 1;
   localparam int IRQ_WAKE = 2;
   localparam int IRQ_W = 3;
   // reset values
   localparam logic [2:0] PRD_RESET = 3'h1;
   localparam logic RES_RESET = 1'h0;
   localparam logic [IRQ_W-1:0] MASK_RESET = 3'h0;
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_TIME_NS = 1000000;
   localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
   localparam logic [19:0] RES_FINE_MS = 20'h009C4;
   localparam logic [19:0] RES_COARSE_MS = 20'h0EA60;
   localparam int WARN_LEAD_MS = 1;
   localparam int WD_TIMEOUT_MS = 1000;
   // processor power modes, one-hot
   typedef enum logic [3:0] {
      MODE_NORMAL = 4'b0001,
      MODE_BROWNOUT = 4'b0010,
      MODE_SLEEP = 4'b0100,
      MODE_DISPLAY = 4'b1000
   } proc_mode_t;
   typedef enum logic [2:0] {
      WAKE_IDLE = 3'b001,
      WAKE_ARMED = 3'b010,
      WAKE_FIRED = 3'b100
   } wake_state_t;
endpackage
`default_nettype wire

// ### verilog/wake_wd.sv
// Notes on behaviour
// - writing arm loads timer from period, resolution
// - normal or brownout mode resets, disarms timer
// - sleep time is period times resolution
// - resolution one minute or 2.5 seconds
// - warning flag set 1 ms before overflow
// - warning clears by zero write, wake fall
// - overflow sets persistent overflow status bit
// - reset input clears overflow status bit
`timescale 1ns/10ps
`default_nettype none
module wake_wd #(
   parameter int TICK_DIV = wake_wd_pkg::TICK_CYCLES,
   parameter int WD_TIMEOUT = wake_wd_pkg::WD_TIMEOUT_MS,
   parameter int WD_W = 16
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [15:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire wake_wd_pkg::proc_mode_t proc_mode,
   input wire logic wake_pin,
   output logic wake_request,
   output logic cpu_reset,
   output logic irq
);
   import wake_wd_pkg::*;

   localparam logic [WD_W-1:0] WD_LAST = WD_W'(WD_TIMEOUT - 1);
   localparam logic [WD_W-1:0] WARN_AT = WD_W'(WD_TIMEOUT - 1 - WARN_LEAD_MS);

   logic ack;
   logic [31:0] next_readdata;
   logic [2:0] sleep_period_count;
   logic sleep_resolution_select;
   logic overflow_status;
   logic overflow_warning;
   logic [IRQ_W-1:0] irq_status;
   logic [IRQ_W-1:0] irq_mask;
   logic [31:0] tick_count;
   logic ms_tick;
   wake_state_t wake_state;
   wake_state_t next_wake_state;
   logic [19:0] wake_count;
   logic [WD_W-1:0] wd_count;
   logic wake_meta;
   logic wake_sync;
   logic wake_prev;

   // one wait state: the first cycle of a request raises waitrequest,
   // the second accepts it, so register reads see settled state
   wire access = read | write;
   wire taken = access & ack;
   wire [13:0] idx = address[15:2];
   wire hit_restart = (idx == IDX_RESTART[13:0]);
   wire hit_ovf = (idx == IDX_OVF_STATUS[13:0]);
   wire hit_wake = (idx == IDX_WAKE_CTRL[13:0]);
   wire hit_flags = (idx == IDX_FLAGS[13:0]);
   wire hit_istat = (idx == IDX_IRQ_STATUS[13:0]);
   wire hit_imask = (idx == IDX_IRQ_MASK[13:0]);
   wire wr_lane = write & taken & byteenable[0];
   assign waitrequest = access & ~ack;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ack <= 1'b0;
      end else begin
         ack <= access & ~ack;
      end
   end

   // read mux; write-only fields read as zero
   always_comb begin
      next_readdata = 32'h0000_0000;
      if (hit_ovf) begin
         next_readdata[OVF_BIT] = overflow_status;
      end else if (hit_wake) begin
         next_readdata[PRD_LSB +: 3] = sleep_period_count;
         next_readdata[RES_BIT] = sleep_resolution_select;
      end else if (hit_flags) begin
         next_readdata[WARN_BIT] = overflow_warning;
      end else if (hit_istat) begin
         next_readdata[IRQ_W-1:0] = irq_status;
      end else if (hit_imask) begin
         next_readdata[IRQ_W-1:0] = irq_mask;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         readdata <= 32'h0000_0000;
      end else if (read & ~ack) begin
         readdata <= next_readdata;
      end
   end

   // millisecond enable; the slow timers count this, not the clock
   assign ms_tick = (tick_count == 32'(TICK_DIV - 1));

   always_ff @(posedge sys_clk) begin
      if (reset || ms_tick) begin
         tick_count <= 32'h0000_0000;
      end else begin
         tick_count <= tick_count + 32'h0000_0001;
      end
   end

   // wake pin is asynchronous: two flops before any logic looks at it
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         wake_meta <= 1'b0;
         wake_sync <= 1'b0;
         wake_prev <= 1'b0;
      end else begin
         wake_meta <= wake_pin;
         wake_sync <= wake_meta;
         wake_prev <= wake_sync;
      end
   end
   wire wake_fall = wake_prev & ~wake_sync;

   // wake control fields
   wire wr_wake = wr_lane & hit_wake;
   wire arm_write = wr_wake & writedata[ARM_BIT];

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         sleep_period_count <= PRD_RESET;
         sleep_resolution_select <= RES_RESET;
      end else if (wr_wake) begin
         sleep_period_count <= writedata[PRD_LSB +: 3];
         sleep_resolution_select <= writedata[RES_BIT];
      end
   end

   // duration in ms ticks: count times 2.5 s or 1 min
   // a count of zero fires on the first tick of sleep
   wire [19:0] res_ms = sleep_resolution_select ? RES_COARSE_MS : RES_FINE_MS;
   wire [22:0] wake_product = 23'(sleep_period_count) * 23'(res_ms);
   wire [19:0] wake_load = wake_product[19:0];
   wire awake_mode = (proc_mode == MODE_NORMAL) | (proc_mode == MODE_BROWNOUT);
   wire sleeping = (proc_mode == MODE_SLEEP) | (proc_mode == MODE_DISPLAY);
   wire wake_hit = (wake_state == WAKE_ARMED) & sleeping & ms_tick
                   & (wake_count == 20'h00000);

   // wake timer state; awake modes hold it reset, so an arm made before sleep is lost
   always_comb begin
      case (wake_state)
         WAKE_IDLE: next_wake_state = arm_write ? WAKE_ARMED : WAKE_IDLE;
         // a fresh arm in the expiry cycle keeps the state armed, yet wake_request and the wake irq still fire
         WAKE_ARMED: next_wake_state = (wake_hit && !arm_write) ? WAKE_FIRED : WAKE_ARMED;
         WAKE_FIRED: next_wake_state = arm_write ? WAKE_ARMED : WAKE_FIRED;
         default: next_wake_state = WAKE_IDLE;
      endcase
      if (awake_mode) begin
         next_wake_state = WAKE_IDLE;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         wake_state <= WAKE_IDLE;
      end else begin
         wake_state <= next_wake_state;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset || awake_mode) begin
         wake_count <= 20'h00000;
      end else if (arm_write) begin
         wake_count <= wake_load;
      end else if (wake_state == WAKE_ARMED && sleeping && ms_tick
                   && wake_count != 20'h00000) begin
         wake_count <= wake_count - 20'h00001;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         wake_request <= 1'b0;
      end else begin
         wake_request <= wake_hit;
      end
   end

   // watchdog; only a byte-lane write with bit 7 set restarts it
   wire wd_restart = wr_lane & hit_restart & writedata[RESTART_BIT];
   wire wd_overflow = ms_tick & (wd_count == WD_LAST) & ~wd_restart;
   wire warn_set = ms_tick & (wd_count == WARN_AT) & ~wd_restart;

   always_ff @(posedge sys_clk) begin
      if (reset || wd_restart || wd_overflow) begin
         wd_count <= '0;
      end else if (ms_tick) begin
         wd_count <= wd_count + WD_W'(1);
      end
   end

   // the processor reset leaves this block alone, so status survives it
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cpu_reset <= 1'b0;
      end else begin
         cpu_reset <= wd_overflow;
      end
   end

   // set wins over every clear
   wire warn_clear = (wr_lane & hit_flags & ~writedata[WARN_BIT]) | wake_fall;
   wire ovf_clear = wr_lane & hit_ovf & ~writedata[OVF_BIT];

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         overflow_warning <= 1'b0;
      end else if (warn_set) begin
         overflow_warning <= 1'b1;
      end else if (warn_clear) begin
         overflow_warning <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         overflow_status <= 1'b0;
      end else if (wd_overflow) begin
         overflow_status <= 1'b1;
      end else if (ovf_clear) begin
         overflow_status <= 1'b0;
      end
   end

   // interrupt status clears on read; a new event the same cycle stays
   wire [IRQ_W-1:0] irq_events = {wake_hit, wd_overflow, warn_set};
   wire stat_read = read & taken & hit_istat;
   // a read clears only the bits it returned; an event that lands between the
   // readdata capture and the accepting edge waits for the next read
   wire [IRQ_W-1:0] irq_keep = stat_read ? (irq_status & ~readdata[IRQ_W-1:0]) : irq_status;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         irq_status <= '0;
         irq_mask <= MASK_RESET;
         irq <= 1'b0;
      end else begin
         irq_status <= irq_keep | irq_events;
         if (wr_lane && hit_imask) begin
            irq_mask <= writedata[IRQ_W-1:0];
         end
         irq <= |((irq_keep | irq_events) & irq_mask);
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   a_arm_loads: assert property (
      arm_write && !awake_mode |=> wake_state == WAKE_ARMED
         && wake_count == $past(wake_load))
      else $error("arm did not load wake timer");

   a_awake_disarm: assert property (
      awake_mode |=> wake_state == WAKE_IDLE && wake_count == 20'h00000)
      else $error("wake timer alive in awake mode");

   a_period_default: assert property (
      $past(reset) |-> sleep_period_count == 3'h1 && !sleep_resolution_select)
      else $error("wake fields wrong after reset");

   a_res_scale: assert property (
      wake_load == 20'(sleep_period_count)
         * (sleep_resolution_select ? 20'h0EA60 : 20'h009C4))
      else $error("wake duration scale wrong");

   a_warn_before_ovf: assert property (
      warn_set |=> overflow_warning ##0 (!wd_overflow)[*2])
      else $error("warning not set ahead of overflow");

   a_warn_clear: assert property (
      overflow_warning && wake_fall && !warn_set |=> !overflow_warning)
      else $error("wake fall did not clear warning");

   a_ovf_status: assert property (
      wd_overflow |=> overflow_status && cpu_reset ##1 !cpu_reset)
      else $error("overflow status or pulse wrong");

   // the default disable would switch this off exactly while reset is high
   a_reset_clears: assert property (@(posedge sys_clk) disable iff (1'b0)
      reset |=> !overflow_status && !overflow_warning)
      else $error("reset left overflow status set");

   a_restart_holds: assert property (
      wd_restart |=> !cpu_reset && wd_count == '0)
      else $error("restart did not clear watchdog");
endmodule
`default_nettype wire

// ### dv/autowake_and_watchdog_status_tb.sv
`timescale 1ns/10ps
`default_nettype none
module autowake_and_watchdog_status_tb;
   import wake_wd_pkg::*;
   logic sys_clk = 0, reset = 1, read = 0, write = 0, wake_pin = 0;
   logic [15:0] address = 16'h0000;
   logic [3:0] be = 4'hF;
   logic [31:0] writedata = 32'h0, readdata, q;
   logic waitrequest, wake_request, cpu_reset, irq;
   proc_mode_t mode = MODE_NORMAL;
   int n_mismatch = 0, cmp_count = 0, cyc = 0, wake_cyc = 0, n_rst = 0, t0, k;
   wake_wd #(.TICK_DIV(10), .WD_TIMEOUT(8), .WD_W(16)) DUT (.sys_clk(sys_clk), .reset(reset),
      .address(address), .read(read), .write(write), .byteenable(be), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest), .proc_mode(mode), .wake_pin(wake_pin),
      .wake_request(wake_request), .cpu_reset(cpu_reset), .irq(irq));
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   // free cycle count and pulse capture; pulses last one cycle, so catch them on the edge
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (wake_request === 1'b1) wake_cyc <= cyc;
      if (cpu_reset === 1'b1) n_rst <= n_rst + 1;
   end
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
         n_mismatch++;
      end
   endtask
   // one bus access; entered just after a rising edge, waitrequest and readdata
   // are judged at the rising edge, where they hold their pre-edge values
   task automatic acc(input logic [15:0] idx, input logic wr, input logic [7:0] d);
      int i;
      address <= {idx[13:0], 2'b00};
      read <= !wr;
      write <= wr;
      writedata <= {24'h0, d};
      for (i = 0; i < 50; i++) begin
         @(posedge sys_clk);
         if (waitrequest === 1'b0) break;
      end
      if (i == 50) begin
         $display("[FAIL] waitrequest expected 0 seen 1");
         n_mismatch++;
         wrap_up();
      end
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      // one idle edge, so the next call never re-raises a strobe in this step
      @(posedge sys_clk);
   endtask
   task automatic rd(input string name, input logic [15:0] idx, input logic [7:0] exp);
      acc(idx, 1'b0, 8'h00);
      chk(name, {24'h0, exp}, q);
   endtask
   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      acc(idx, 1'b1, d);
   endtask
   // bounded wait on a pulse output, 0 watchdog reset, 1 wake request
   task automatic wait_for(input int sel, input int lim);
      int i;
      for (i = 0; i < lim; i++) begin
         @(negedge sys_clk);
         if ((sel == 0 ? cpu_reset : wake_request) === 1'b1) break;
      end
      if (i == lim) begin
         $display("[FAIL] pulse %0d expected 1 seen none", sel);
         n_mismatch++;
         wrap_up();
      end
      @(posedge sys_clk);
   endtask
   initial begin
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      rd("ctrl reset", IDX_WAKE_CTRL, 8'h01);
      rd("ovf reset", IDX_OVF_STATUS, 8'h00);
      rd("flags reset", IDX_FLAGS, 8'h00);
      rd("mask reset", IDX_IRQ_MASK, 8'h00);
      rd("restart reads", IDX_RESTART, 8'h00);
      rd("unmapped", 16'h1234, 8'h00);
      be <= 4'hE;
      wr(IDX_WAKE_CTRL, 8'h0B);
      be <= 4'hF;
      rd("ctrl lane off", IDX_WAKE_CTRL, 8'h01);
      wr(IDX_WAKE_CTRL, 8'h0B);
      rd("ctrl fields", IDX_WAKE_CTRL, 8'h0B);
      wr(IDX_IRQ_MASK, 8'h02);
      // first overflow with no restart
      wait_for(0, 200);
      repeat (2) @(posedge sys_clk);
      chk("irq on", 32'h1, {31'h0, irq});
      rd("ovf set", IDX_OVF_STATUS, 8'h04);
      rd("warn set", IDX_FLAGS, 8'h01);
      rd("irq status", IDX_IRQ_STATUS, 8'h03);
      repeat (2) @(posedge sys_clk);
      chk("irq off", 32'h0, {31'h0, irq});
      rd("irq cleared", IDX_IRQ_STATUS, 8'h00);
      wr(IDX_FLAGS, 8'h00);
      rd("warn write clr", IDX_FLAGS, 8'h00);
      wr(IDX_OVF_STATUS, 8'h00);
      rd("ovf boot clr", IDX_OVF_STATUS, 8'h00);
      // second overflow, warning cleared by a fall of the wake line
      wait_for(0, 200);
      wake_pin <= 1'b1;
      repeat (4) @(posedge sys_clk);
      wake_pin <= 1'b0;
      repeat (4) @(posedge sys_clk);
      rd("warn pin clr", IDX_FLAGS, 8'h00);
      rd("ovf again", IDX_OVF_STATUS, 8'h04);
      reset <= 1'b1;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      rd("ovf by reset", IDX_OVF_STATUS, 8'h00);
      // byte-wide restarts keep the watchdog quiet
      t0 = n_rst;
      for (k = 0; k < 6; k++) begin
         wr(IDX_RESTART, 8'h80);
         repeat (30) @(posedge sys_clk);
      end
      chk("no overflow", t0, n_rst);
      // arm three cycles ahead of sleep while in normal mode: the timer is held
      // reset there, so the arm is lost
      wr(IDX_WAKE_CTRL, 8'h80);
      repeat (3) @(posedge sys_clk);
      mode <= MODE_SLEEP;
      repeat (17) @(posedge sys_clk);
      chk("arm lost", 32'h0, wake_cyc);
      wr(IDX_RESTART, 8'h80);
      // the period field now holds zero, so the timer fires on the first tick
      wr(IDX_WAKE_CTRL, 8'h80);
      wait_for(1, 30);
      rd("irq wake", IDX_IRQ_STATUS, 8'h04);
      // one count of 2.5 s in display-only mode, watchdog kept alive; the arm
      // loads the fields already held, so they are written first
      mode <= MODE_DISPLAY;
      t0 = n_rst;
      wr(IDX_WAKE_CTRL, 8'h01);
      wr(IDX_WAKE_CTRL, 8'h81);
      k = cyc;
      while (wake_cyc < k && cyc < k + 27000) begin
         wr(IDX_RESTART, 8'h80);
         repeat (38) @(posedge sys_clk);
      end
      chk("wake early", 32'h1, {31'h0, wake_cyc >= k + 25000});
      chk("wake late", 32'h1, {31'h0, wake_cyc <= k + 25013});
      chk("no overflow sleep", t0, n_rst);
      wrap_up();
   end
endmodule
`default_nettype wire
